/* core/bsf_consts.svh */
// Register offsets, field positions, reset values and counts of the sample input.
`ifndef BSF_CONSTS_SVH
`define BSF_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the host address bus
// ----------------------------------------------------------------------
`define BSF_ADDR_I_SAMPLE 7'h00
`define BSF_ADDR_Q_SAMPLE 7'h01
`define BSF_ADDR_MAIN 7'h0c
`define BSF_ADDR_SERIAL 7'h11
`define BSF_ADDR_I_SLOT 7'h12
`define BSF_ADDR_Q_SLOT 7'h13
`define BSF_ADDR_XFER 7'h17

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BSF_MC_SW_TX_EN 0
`define BSF_MC_NO_FULL_RST 1
`define BSF_MC_INDEP 3
`define BSF_MC_THR_HI 10
`define BSF_MC_THR_LO 8
`define BSF_SC_SERIAL 15
`define BSF_SC_MODE_HI 13
`define BSF_SC_MODE_LO 12
`define BSF_SC_DIV_HI 11
`define BSF_SC_DIV_LO 8
`define BSF_SC_LEN_HI 3
`define BSF_SC_LEN_LO 2
`define BSF_SC_SEL_HI 1
`define BSF_SC_SEL_LO 0
`define BSF_XC_B2B_HI 14
`define BSF_XC_B2B_LO 13
`define BSF_SLOT_HI 9

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define BSF_REG_RESET 16'h0000
`define BSF_DEPTH 7
`define BSF_X32_SHIFT 5
`define BSF_PER_W 16

`endif

/* core/bsf_pkg.sv */
// Types shared by the sample input channel and its FIFO.
package bsf_pkg;
    typedef logic [15:0] bsf_word_t;
    typedef enum logic [1:0] {
        BSF_CLK_MASTER,
        BSF_CLK_DIV,
        BSF_CLK_X32,
        BSF_CLK_SPARE
    } bsf_clk_mode_t;
    typedef enum logic {
        BSF_SER_IDLE,
        BSF_SER_SHIFT
    } bsf_ser_state_t;
endpackage : bsf_pkg

/* core/bsf_fifo.sv */
// Sample pair FIFO with valid and ready on both sides.
`include "bsf_consts.svh"

module bsf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = `BSF_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    import bsf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // Pointers wrap at DEPTH, which need not be a power of two.
    function automatic logic [AW-1:0] bsf_next_ptr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bsf_next_ptr

    // A full FIFO still takes a word when one leaves in the same cycle.
    assign in_ready_o = (count != CW'(DEPTH)) || out_ready_i;
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;
    assign out_data_o = mem[rd_ptr];
    assign count_o = count;

    // Storage carries no reset; only the pointers define what is valid.
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointer and occupancy bookkeeping.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || flush_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= bsf_next_ptr(wr_ptr);
            end
            if (pop)
            begin
                rd_ptr <= bsf_next_ptr(rd_ptr);
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_depth_bound: assert property (
        count <= CW'(DEPTH))
        else $error("FIFO holds more pairs than its depth");
    chk_push_pop_hold: assert property (
        push && pop && !flush_i |=> $stable(count))
        else $error("Occupancy moved on simultaneous push and pop");
    chk_push_count: assert property (
        push && !pop && !flush_i |=> count == $past(count) + 1'b1)
        else $error("Occupancy did not rise on push");
    chk_pop_count: assert property (
        pop && !push && !flush_i |=> count == $past(count) - 1'b1)
        else $error("Occupancy did not fall on pop");
endmodule : bsf_fifo

/* core/bsf_top.sv */
// Baseband sample input channel: host and serial entry into the pair FIFO.
//
// Function
// - Serial control bit 15 picks serial input, else host writes.
// - In serial mode the channel drives clock and frame, samples data.
// - Serial clock at master rate, divided rate or 32x sample rate.
// - In 32x mode, 0x17 bits 14:13 allow gapless transfers.
// - Start at first serial clock after sample clock; one-clock frame.
// - Frame only while transmit enable pin or software enable is set.
// - Main control bit 3 lets serial requests continue with the pin low.
// - Ten-bit I and Q slot counters count clocks from frame to last bit.
// - Words arrive MSB first; slot values alone fix I and Q order.
// - Received word of 4, 8, 12 or 16 bits is left-justified.
// - Serial control bits 1:0 pick one of four serial data inputs.
// - Host writes Q to 0x1, then I to 0x0; 0x0 pushes the pair.
// - Host may read back the FIFO's first location.
// - The FIFO holds at most seven pairs.
// - Occupancy rises on each write into the FIFO unless a request takes a pair in the same cycle.
// - Serial pair enters FIFO only when both words are complete.
// - Each downstream request takes the oldest pair and lowers occupancy unless a pair enters in the same cycle.
// - Empty FIFO on request delivers zero samples.
// - Write into a full FIFO with no request in that cycle soft-resets the channel unless bit 1 set.
// - Ready output asserts when depth is at or below the threshold.
`include "bsf_consts.svh"

module bsf_top #(
    parameter int DEPTH = `BSF_DEPTH,
    parameter int PER_W = `BSF_PER_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Host parallel bus
    input wire logic [6:0] addr_i,
    input wire bsf_pkg::bsf_word_t data_i,
    output bsf_pkg::bsf_word_t data_o,
    output logic data_oe_o,
    input wire logic cs_n_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // Transmit enable
    input wire logic transmit_enable_pin_i,
    // Serial receiver
    input wire logic sample_clk_i,
    input wire logic [3:0] sdata_i,
    output logic sclk_o,
    output logic frame_o,
    // Downstream filter side
    input wire logic rd_req_i,
    output bsf_pkg::bsf_word_t sample_i_o,
    output bsf_pkg::bsf_word_t sample_q_o,
    output logic sample_valid_o,
    output logic fifo_depth_ready_o
);
    import bsf_pkg::*;

    localparam int CW = $clog2(DEPTH+1);

    // ----------------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------------
    bsf_word_t main_control;
    bsf_word_t serial_input_control;
    bsf_word_t i_time_slot_count;
    bsf_word_t q_time_slot_count;
    bsf_word_t serial_transfer_control;
    bsf_word_t q_hold;
    logic wr_acc;
    logic rd_acc;

    assign wr_acc = !cs_n_i && wr_i;
    assign rd_acc = !cs_n_i && rd_i;

    // Host writes; the sample words only feed the FIFO and are not stored
    // apart from the Q word, which waits for its I partner.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            main_control <= `BSF_REG_RESET;
            serial_input_control <= `BSF_REG_RESET;
            i_time_slot_count <= `BSF_REG_RESET;
            q_time_slot_count <= `BSF_REG_RESET;
            serial_transfer_control <= `BSF_REG_RESET;
            q_hold <= `BSF_REG_RESET;
        end
        else if (wr_acc)
        begin
            case (addr_i)
                `BSF_ADDR_Q_SAMPLE: q_hold <= data_i;
                `BSF_ADDR_MAIN: main_control <= data_i;
                `BSF_ADDR_SERIAL: serial_input_control <= data_i;
                `BSF_ADDR_I_SLOT: i_time_slot_count <= data_i;
                `BSF_ADDR_Q_SLOT: q_time_slot_count <= data_i;
                `BSF_ADDR_XFER: serial_transfer_control <= data_i;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------------
    logic serial_mode;
    bsf_clk_mode_t clk_mode;
    logic [4:0] word_len;
    logic sbit;
    logic frame_ok;
    logic b2b_en;
    logic [9:0] i_slot;
    logic [9:0] q_slot;

    assign serial_mode = serial_input_control[`BSF_SC_SERIAL];
    assign clk_mode = bsf_clk_mode_t'(
        serial_input_control[`BSF_SC_MODE_HI:`BSF_SC_MODE_LO]);
    assign word_len = {1'b0,
        serial_input_control[`BSF_SC_LEN_HI:`BSF_SC_LEN_LO], 2'b00} + 5'd4;
    assign sbit = sdata_i[serial_input_control[
        `BSF_SC_SEL_HI:`BSF_SC_SEL_LO]];
    // Pin alone, or software enable when the pin is declared irrelevant.
    assign frame_ok = transmit_enable_pin_i ||
        (main_control[`BSF_MC_SW_TX_EN] && main_control[`BSF_MC_INDEP]);
    assign b2b_en = (clk_mode == BSF_CLK_X32) &&
        (&serial_transfer_control[`BSF_XC_B2B_HI:`BSF_XC_B2B_LO]);
    assign i_slot = i_time_slot_count[`BSF_SLOT_HI:0];
    assign q_slot = q_time_slot_count[`BSF_SLOT_HI:0];

    // ----------------------------------------------------------------------
    // Serial clock divider
    // ----------------------------------------------------------------------
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] per_len;
    logic [PER_W-1:0] tick_cnt;
    logic [PER_W-1:0] tick_lim;
    logic tick;

    // The 32x rate is derived from the measured sample period, so it only
    // settles one sample period after the sample clock starts.
    always_comb
    begin
        unique case (clk_mode)
            BSF_CLK_MASTER: tick_lim = '0;
            BSF_CLK_DIV: tick_lim = PER_W'(
                serial_input_control[`BSF_SC_DIV_HI:`BSF_SC_DIV_LO]);
            BSF_CLK_X32: tick_lim = per_len >> `BSF_X32_SHIFT;
            BSF_CLK_SPARE: tick_lim = '0;
        endcase
    end

    assign tick = (tick_cnt >= tick_lim);

    // Tick counter restarts on the sample clock in 32x mode to stay aligned.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tick_cnt <= '0;
        end
        else if (tick || (clk_mode == BSF_CLK_X32 && sample_clk_i))
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Sample period measurement for the 32x mode.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            per_cnt <= '0;
            per_len <= '0;
        end
        else if (sample_clk_i)
        begin
            per_cnt <= '0;
            per_len <= per_cnt + 1'b1;
        end
        else
        begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------------
    bsf_ser_state_t state;
    logic soft_rst;
    logic pending;
    logic b2b_go;
    logic start;
    logic shift_tick;
    logic [9:0] pos;
    logic [9:0] pos_eff;
    logic [15:0] i_sh;
    logic [15:0] q_sh;
    logic i_done;
    logic q_done;
    logic ser_push;

    assign start = tick && serial_mode && (state == BSF_SER_IDLE) &&
        frame_ok && (pending || b2b_go);
    assign shift_tick = tick && (start || state == BSF_SER_SHIFT);
    assign pos_eff = start ? 10'h000 : pos;
    assign ser_push = (state == BSF_SER_SHIFT) && i_done && q_done;

    // A sample clock arriving as a transfer starts is kept, not dropped.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || soft_rst)
        begin
            pending <= 1'b0;
            b2b_go <= 1'b0;
        end
        else
        begin
            pending <= sample_clk_i || (pending && !start);
            b2b_go <= (ser_push && b2b_en) ||
                (b2b_go && !start && b2b_en);
        end
    end

    // Transfer state.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || soft_rst)
        begin
            state <= BSF_SER_IDLE;
        end
        else
        begin
            unique case (state)
                BSF_SER_IDLE: if (start) state <= BSF_SER_SHIFT;
                BSF_SER_SHIFT:
                    if (ser_push || !serial_mode) state <= BSF_SER_IDLE;
            endcase
        end
    end

    // Slot position counts serial clocks with the frame clock as zero.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            pos <= '0;
        end
        else if (shift_tick)
        begin
            pos <= pos_eff + 1'b1;
        end
    end

    // Each word takes the bits that end at its slot, MSB first, so two
    // channels can share one data line by using disjoint slots.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            i_sh <= '0;
            q_sh <= '0;
            i_done <= 1'b0;
            q_done <= 1'b0;
        end
        else
        begin
            if (start || ser_push)
            begin
                i_done <= 1'b0;
                q_done <= 1'b0;
            end
            if (shift_tick && pos_eff <= i_slot &&
                (i_slot - pos_eff) < 10'(word_len))
            begin
                i_sh <= {i_sh[14:0], sbit};
            end
            if (shift_tick && pos_eff <= q_slot &&
                (q_slot - pos_eff) < 10'(word_len))
            begin
                q_sh <= {q_sh[14:0], sbit};
            end
            if (shift_tick && pos_eff == i_slot)
            begin
                i_done <= 1'b1;
            end
            if (shift_tick && pos_eff == q_slot)
            begin
                q_done <= 1'b1;
            end
        end
    end

    // Serial clock and frame strobe driven by the channel.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || soft_rst)
        begin
            sclk_o <= 1'b0;
            frame_o <= 1'b0;
        end
        else
        begin
            sclk_o <= tick && serial_mode;
            if (start)
            begin
                frame_o <= 1'b1;
            end
            else if (tick)
            begin
                frame_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // FIFO entry, overflow and downstream side
    // ----------------------------------------------------------------------
    logic par_push;
    logic push_req;
    logic [31:0] push_data;
    logic in_ready;
    logic out_valid;
    logic [31:0] head;
    logic [CW-1:0] count;
    logic overflow;

    assign par_push = wr_acc && (addr_i == `BSF_ADDR_I_SAMPLE) &&
        !serial_mode;
    assign push_req = par_push || ser_push;
    // Left-justify the serial words to the word length.
    assign push_data = ser_push ? {i_sh << (5'd16 - word_len),
        q_sh << (5'd16 - word_len)} : {data_i, q_hold};
    assign overflow = push_req && !in_ready;

    // The soft reset lands one cycle later and flushes the FIFO and the serial transfer state.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            soft_rst <= 1'b0;
        end
        else
        begin
            soft_rst <= overflow && !main_control[`BSF_MC_NO_FULL_RST];
        end
    end

    bsf_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .flush_i(soft_rst),
        .in_valid_i(push_req),
        .in_ready_o(in_ready),
        .in_data_i(push_data),
        .out_valid_o(out_valid),
        .out_ready_i(rd_req_i),
        .out_data_o(head),
        .count_o(count)
    );

    // Downstream gets zeros rather than a stall when nothing is stored.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sample_i_o <= '0;
            sample_q_o <= '0;
            sample_valid_o <= 1'b0;
            fifo_depth_ready_o <= 1'b0;
        end
        else
        begin
            sample_valid_o <= rd_req_i;
            if (rd_req_i)
            begin
                sample_i_o <= out_valid ? head[31:16] : 16'h0000;
                sample_q_o <= out_valid ? head[15:0] : 16'h0000;
            end
            fifo_depth_ready_o <= (count <= CW'(main_control[
                `BSF_MC_THR_HI:`BSF_MC_THR_LO]));
        end
    end

    // Host read-back; the sample addresses show the FIFO head.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= '0;
            data_oe_o <= 1'b0;
        end
        else
        begin
            data_oe_o <= rd_acc;
            if (rd_acc)
            begin
                case (addr_i)
                    `BSF_ADDR_I_SAMPLE: data_o <= head[31:16];
                    `BSF_ADDR_Q_SAMPLE: data_o <= head[15:0];
                    `BSF_ADDR_MAIN: data_o <= main_control;
                    `BSF_ADDR_SERIAL: data_o <= serial_input_control;
                    `BSF_ADDR_I_SLOT: data_o <= i_time_slot_count;
                    `BSF_ADDR_Q_SLOT: data_o <= q_time_slot_count;
                    `BSF_ADDR_XFER: data_o <= serial_transfer_control;
                    default: data_o <= '0;
                endcase
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_frame_start;
        $rose(frame_o);
    endsequence

    chk_parallel_push: assert property (
        par_push && in_ready && !rd_req_i |=> count == $past(count) + 1'b1)
        else $error("I sample write did not push a pair");
    chk_parallel_quiet: assert property (
        !serial_mode [*2] |-> !frame_o)
        else $error("Frame strobe seen in parallel mode");
    chk_frame_enable: assert property (
        s_frame_start |-> $past(transmit_enable_pin_i) ||
            $past(main_control[`BSF_MC_SW_TX_EN]))
        else $error("Frame started without any transmit enable");
    chk_frame_indep: assert property (
        s_frame_start |-> $past(transmit_enable_pin_i) ||
            $past(main_control[`BSF_MC_INDEP]))
        else $error("Frame started with pin low while dependent");
    chk_frame_width: assert property (
        s_frame_start and (clk_mode == BSF_CLK_MASTER && !soft_rst)
        |=> !frame_o)
        else $error("Frame strobe longer than one serial clock");
    chk_full_reset: assert property (
        overflow && !main_control[`BSF_MC_NO_FULL_RST] |=> ##1 count == '0)
        else $error("Full write did not reset the channel");
    chk_empty_zero: assert property (
        rd_req_i && !out_valid |=> sample_valid_o && sample_i_o == 16'h0000)
        else $error("Empty request did not deliver zero");
    chk_serial_pair: assert property (
        ser_push |-> $past(shift_tick) && serial_mode)
        else $error("Serial pair pushed outside a transfer");
endmodule : bsf_top

/* verif/bsf_src_model.sv */
// Serial sample source that answers the channel's frame on one data line.
module bsf_src_model #(
    parameter int WBITS = 4
) (
    // Clock
    input wire logic clock_i,
    // Channel side
    input wire logic sclk_i,
    input wire logic frame_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] i_word_i,
    input wire logic [15:0] q_word_i,
    output logic [3:0] sdata_o
);
    int pos = 0;
    logic was_frame = 1'b0;
    logic bit_v = 1'b0;
    logic [3:0] lines_v = 4'h0;

    // ------------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------------
    // The frame starts the slot count; I goes first, then Q, MSB first.
    // Bits move only on serial clock pulses, so divided rates are followed.
    // Idle and unselected lines carry the inverse, so stale bits show up.
    always @(negedge clock_i)
    begin
        if (sclk_i)
        begin
            if (frame_i && !was_frame)
                pos = 1;
            else if (pos != 0 && pos < 2 * WBITS)
                pos = pos + 1;
            else
                pos = 0;
            was_frame = frame_i;
            if (pos >= 1 && pos <= WBITS)
                bit_v = i_word_i[16 - pos];
            else if (pos > WBITS)
                bit_v = q_word_i[16 - pos + WBITS];
            else
                bit_v = ~bit_v;
        end
        lines_v = {4{~bit_v}};
        lines_v[sel_i] = bit_v;
        sdata_o = lines_v;
    end
endmodule : bsf_src_model

/* verif/bsf_top_tb.sv */
// Self-checking bench for the sample input channel.
`include "bsf_consts.svh"
`define BSF_CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end

module bsf_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bsf_pkg::*;

    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [6:0] addr_i = 7'h00;
    bsf_word_t data_i = 16'h0000;
    bsf_word_t data_o, sample_i_o, sample_q_o;
    logic cs_n_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, pin = 1'b0;
    logic sample_clk_i = 1'b0, rd_req_i = 1'b0, frame_d = 1'b0;
    logic data_oe_o, sclk_o, frame_o, sample_valid_o, fifo_depth_ready_o;
    logic [3:0] sdata;
    int err_total = 0, num_checks = 0, frame_cnt = 0;

    bsf_top i_bsf_top (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .cs_n_i(cs_n_i), .wr_i(wr_i), .rd_i(rd_i),
        .transmit_enable_pin_i(pin), .sample_clk_i(sample_clk_i),
        .sdata_i(sdata), .sclk_o(sclk_o), .frame_o(frame_o),
        .rd_req_i(rd_req_i), .sample_i_o(sample_i_o),
        .sample_q_o(sample_q_o), .sample_valid_o(sample_valid_o),
        .fifo_depth_ready_o(fifo_depth_ready_o));
    bsf_src_model #(.WBITS(4)) i_bsf_src_model (.clock_i(clock_i),
        .sclk_i(sclk_o), .frame_i(frame_o), .sel_i(2'h2),
        .i_word_i(16'ha000),
        .q_word_i(16'h5000), .sdata_o(sdata));

    // ------------------------------------------------------------------
    // Clock, frame counter and watchdog
    // ------------------------------------------------------------------
    // Clock at 40 MHz.
    always #12.5 clock_i = ~clock_i;
    // Count frame starts, so a frame that should be held back is seen.
    always @(posedge clock_i)
    begin
        if (frame_o === 1'b1 && frame_d !== 1'b1)
            frame_cnt++;
        frame_d <= frame_o;
    end
    // The tests need about 200 cycles; a hang stops well past that.
    initial
    begin
        #100000;
        err_total++;
        results();
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic host_wr(input logic [6:0] a, input bsf_word_t d);
        @(negedge clock_i) {cs_n_i, wr_i, addr_i, data_i} = {2'b01, a, d};
        @(negedge clock_i) {cs_n_i, wr_i} = 2'b10;
    endtask : host_wr
    task automatic host_rd(input logic [6:0] a, input bsf_word_t e);
        @(negedge clock_i) {cs_n_i, rd_i, addr_i} = {2'b01, a};
        // The enable stands for one cycle only, so it is judged right away.
        @(negedge clock_i) {cs_n_i, rd_i} = 2'b10;
        `BSF_CHK("data_oe", 1'b1, data_oe_o)
        `BSF_CHK("read data", e, data_o)
    endtask : host_rd
    // One downstream request; the pair is judged while the valid stands.
    task automatic pop_chk(input bsf_word_t ei, input bsf_word_t eq);
        @(negedge clock_i) rd_req_i = 1'b1;
        @(negedge clock_i) rd_req_i = 1'b0;
        `BSF_CHK("valid", 1'b1, sample_valid_o)
        `BSF_CHK("sample i", ei, sample_i_o)
        `BSF_CHK("sample q", eq, sample_q_o)
    endtask : pop_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        host_wr(`BSF_ADDR_MAIN, 16'h0702);
        host_rd(`BSF_ADDR_MAIN, 16'h0702);
        host_rd(7'h20, 16'h0000);
        host_wr(`BSF_ADDR_MAIN, 16'h0000);
    endtask : t_regs
    task automatic t_par;
        host_wr(`BSF_ADDR_Q_SAMPLE, 16'h1234);
        host_wr(`BSF_ADDR_I_SAMPLE, 16'habcd);
        repeat (2) @(negedge clock_i);
        `BSF_CHK("depth ready", 1'b0, fifo_depth_ready_o)
        host_rd(`BSF_ADDR_I_SAMPLE, 16'habcd);
        host_rd(`BSF_ADDR_Q_SAMPLE, 16'h1234);
        pop_chk(16'habcd, 16'h1234);
        pop_chk(16'h0000, 16'h0000);
    endtask : t_par
    // Eight pairs into seven places; the main bit decides the outcome.
    task automatic t_fill(input logic keep);
        host_wr(`BSF_ADDR_MAIN, {14'h0000, keep, 1'b0});
        for (int k = 0; k < 8; k++)
        begin
            // Same-address accesses land four clocks apart.
            host_wr(`BSF_ADDR_Q_SAMPLE, 16'h0100 + 16'(k));
            host_wr(`BSF_ADDR_I_SAMPLE, 16'(k));
        end
        for (int k = 0; k < 7 && keep; k++)
            pop_chk(16'(k), 16'h0100 + 16'(k));
        pop_chk(16'h0000, 16'h0000);
        `BSF_CHK("depth ready", 1'b1, fifo_depth_ready_o)
    endtask : t_fill
    task automatic t_ser;
        pin = 1'b1;
        host_wr(`BSF_ADDR_I_SLOT, 16'h0004);
        host_wr(`BSF_ADDR_Q_SLOT, 16'h0008);
        host_wr(`BSF_ADDR_SERIAL, 16'h8002);
        @(negedge clock_i) sample_clk_i = 1'b1;
        @(negedge clock_i) sample_clk_i = 1'b0;
        repeat (20) @(negedge clock_i);
        `BSF_CHK("frames", 1, frame_cnt)
        `BSF_CHK("sclk", 1'b1, sclk_o)
        pop_chk(16'ha000, 16'h5000);
        pin = 1'b0;
        @(negedge clock_i) sample_clk_i = 1'b1;
        @(negedge clock_i) sample_clk_i = 1'b0;
        repeat (20) @(negedge clock_i);
        `BSF_CHK("frames", 1, frame_cnt)
    endtask : t_ser
    // Divided clock with the pin low; software enable and independence on.
    task automatic t_ser_div;
        host_wr(`BSF_ADDR_SERIAL, 16'h9102);
        @(negedge clock_i) sample_clk_i = 1'b1;
        @(negedge clock_i) sample_clk_i = 1'b0;
        host_wr(`BSF_ADDR_MAIN, 16'h0009);
        repeat (30) @(negedge clock_i);
        `BSF_CHK("frames", 2, frame_cnt)
        pop_chk(16'ha000, 16'h5000);
    endtask : t_ser_div

    task automatic results;
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_regs();
        t_par();
        t_fill(1'b1);
        t_fill(1'b0);
        t_ser();
        t_ser_div();
        results();
    end
endmodule : bsf_top_tb
